//--- hdl/ioxp_top.sv
// Serial two-wire slave with eight open-drain quasi-bidirectional lines.
// Assumes the bus pins, straps and port lines are asynchronous to core_clk
// and that the core clock runs at least eight times faster than the bus clock.
//
// What this block does
// - At reset all eight line latches are one, so every line is released.
// - At reset the change alert output is released.
// - The data wire is only ever pulled low or released by us.
// - Start is data falling with clock high; stop is data rising with clock high.
// - One bit per clock pulse; the driver keeps data stable while clock is high.
// - Every byte gets a ninth acknowledge clock, held low by the receiver.
// - We acknowledge written bytes; the master acknowledges read bytes.
// - The first byte holds a 7-bit identity then a direction bit, one for read.
// - Upper identity bits are 0100 or 0111 by parameter; lower three are straps.
// - A read returns actual pin levels of all eight lines and clears the alert.
// - While the master acknowledges, fresh port bytes keep being sent.
// - Port pins are sampled during the acknowledge before each read byte.
// - Each written byte loads the eight latches; zero pulls a line low.
// - Every byte of a multi-byte write updates all eight lines again.
// - At each read byte acknowledge detection restarts and the alert is released.
// - An alert released during a read stays released until stop.
// - The byte sent becomes the new reference for change detection.
// - In a write we acknowledge the identity and every data byte until stop.
// - Any edge on a released input line raises the alert.
// - The alert drops when the line returns, or on a read or a write.
// - Write clears the alert on the fall that starts the ack clock; read on the ack rising edge.
module ioxp_top #(
  parameter logic HIGH_RANGE = 1'b0        // Zero selects 0100xxx, one selects 0111xxx
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      slave_id_strap_0,
  input  wire logic                      slave_id_strap_1,
  input  wire logic                      slave_id_strap_2,
  input  wire logic [ioxp_pkg::IO_W-1:0]  io_lines_in,
  output logic      [ioxp_pkg::IO_W-1:0]  io_lines_out,
  output logic      [ioxp_pkg::IO_W-1:0]  io_lines_oe,
  output logic                           alert_n_out,
  output logic                           alert_n_oe
);

  import ioxp_pkg::*;

  // ==========================================================================
  // Declarations
  logic [1:0]        rst_pipe;
  logic              rst_n;
  logic              scl_s;
  logic              sda_s;
  logic              scl_q;
  logic              sda_q;
  logic [STRP_W-1:0] strap_s;
  logic [IO_W-1:0]   io_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start;
  logic              stop;
  ioxp_state_t       state;
  logic [2:0]        cnt;
  logic              full;
  logic [IO_W-1:0]   rx;
  logic              is_read;
  logic              master_ack;
  logic [IO_W-1:0]   snap;
  logic [IO_W-1:0]   tx;
  logic              hold;
  logic [ID_W-1:0]   own_id;
  logic              id_match;
  logic              rd_rearm;
  logic              wr_load;
  logic              rearm;
  logic [IO_W-1:0]   new_ref;
  logic              alert;

  // ==========================================================================
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe <= '0;
    else if (clk_en)
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_n = rst_pipe[1];

  // ==========================================================================
  // Pin synchronisers
  ioxp_sync #(.W(2), .INIT(BUS_IDLE)) u_sync_bus (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .d        ({scl_in, sda_in}),
    .q        ({scl_s, sda_s})
  );

  ioxp_sync #(.W(STRP_W), .INIT(STRP_RST)) u_sync_strap (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .d        ({slave_id_strap_2, slave_id_strap_1, slave_id_strap_0}),
    .q        (strap_s)
  );

  ioxp_sync #(.W(IO_W), .INIT(IO_IDLE)) u_sync_io (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .d        (io_lines_in),
    .q        (io_s)
  );

  // ==========================================================================
  // Bus edge and condition detection; the clock is only ever sampled
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start    = scl_s && scl_q && sda_q && !sda_s;
  assign stop     = scl_s && scl_q && !sda_q && sda_s;

  // Identity: fixed upper nibble by variant, straps below
  assign own_id   = {(HIGH_RANGE ? ID_HI_HIGH_RANGE : ID_HI_LOW_RANGE), strap_s};
  assign id_match = (rx[IO_W-1:1] == own_id);

  // ==========================================================================
  // Bit-level state machine; a start anywhere restarts the address phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cnt   <= CNT_RST;
      full  <= 1'b0;
      rx    <= BYTE_RST;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        state <= ST_ADDR;
        cnt   <= CNT_RST;
        full  <= 1'b0;
      end
      else if (stop)
        state <= ST_IDLE;
      else
      begin
        case (state)
          ST_ADDR, ST_WR_DATA:
          begin
            // Bits counted on rises, so the fall right after start is not a bit
            if (scl_rise)
            begin
              rx   <= {rx[IO_W-2:0], sda_s};
              cnt  <= cnt + 3'h1;
              full <= (cnt == LAST_BIT);
            end
            else if (scl_fall && full)
            begin
              full <= 1'b0;
              if (state == ST_WR_DATA)
                state <= ST_WR_ACK;
              else if (id_match)
                state <= ST_ADDR_ACK;
              else
                state <= ST_IGNORE;
            end
          end
          ST_ADDR_ACK:
            if (scl_fall)
            begin
              cnt   <= CNT_RST;
              state <= is_read ? ST_RD_DATA : ST_WR_DATA;
            end
          ST_WR_ACK:
            if (scl_fall)
              state <= ST_WR_DATA;
          ST_RD_DATA:
            // Bits counted on falls: each of the first seven falls shifts the next bit out
            if (scl_fall)
            begin
              cnt <= cnt + 3'h1;
              if (cnt == LAST_BIT)
                state <= ST_RD_ACK;
            end
          ST_RD_ACK:
            if (scl_fall)
              state <= master_ack ? ST_RD_DATA : ST_IGNORE;
          default:
            state <= state;
        endcase
      end
    end
  end

  // ==========================================================================
  // Direction bit and the master's acknowledge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      is_read    <= 1'b0;
      master_ack <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == ST_ADDR && scl_fall && full)
        is_read <= (rx[0] == RW_READ);
      if (state == ST_RD_ACK && scl_rise)
        master_ack <= !sda_s;
    end
  end

  // ==========================================================================
  // Port snapshot, taken on the rise of each acknowledge ahead of a read byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      snap <= IO_IDLE;
    else if (clk_en && scl_rise && (state == ST_ADDR_ACK || state == ST_RD_ACK))
      snap <= io_s;
  end

  // ==========================================================================
  // Data wire drive: changes on clock falls, or is released at start or stop, so it is otherwise stable while high
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_oe <= 1'b0;
      tx     <= BYTE_RST;
    end
    else if (clk_en)
    begin
      if (start || stop)
        sda_oe <= 1'b0;
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
            if (full)
              sda_oe <= id_match;
          ST_WR_DATA:
            if (full)
              sda_oe <= 1'b1;
          ST_ADDR_ACK, ST_RD_ACK:
            if ((state == ST_ADDR_ACK && is_read) || (state == ST_RD_ACK && master_ack))
            begin
              tx     <= snap;
              sda_oe <= !snap[MSB];
            end
            else
              sda_oe <= 1'b0;
          ST_RD_DATA:
            if (cnt == LAST_BIT)
              sda_oe <= 1'b0;                        // Release for the master's ack
            else
            begin
              tx     <= {tx[IO_W-2:0], 1'b0};
              sda_oe <= !tx[MSB-1];
            end
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  assign sda_out = DRIVE_LOW;

  // ==========================================================================
  // Output latches: a zero pulls the line, a one releases it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      io_lines_oe <= PULL_RST;
    else if (clk_en && wr_load)
      io_lines_oe <= ~rx;
  end

  assign io_lines_out = {IO_W{DRIVE_LOW}};

  // ==========================================================================
  // Detection restart points; a read restarts on the ack rise, a write on the fall
  assign rd_rearm = clk_en && state == ST_RD_ACK && scl_rise && !start && !stop;
  assign wr_load  = clk_en && state == ST_WR_DATA && scl_fall && full && !start && !stop;
  assign rearm    = rd_rearm || wr_load;
  assign new_ref  = rd_rearm ? snap : io_s;

  // Release held from the first read byte acknowledge until stop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold <= 1'b0;
    else if (clk_en)
    begin
      if (rd_rearm)
        hold <= 1'b1;
      else if (stop)
        hold <= 1'b0;
    end
  end

  ioxp_chg u_chg (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pins     (io_s),
    .in_mask  (~io_lines_oe),
    .rearm    (rearm),
    .new_ref  (new_ref),
    .hold     (hold),
    .alert    (alert)
  );

  assign alert_n_out = DRIVE_LOW;
  assign alert_n_oe  = alert;

  // ==========================================================================
  // Checks
  a_reset_release: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (io_lines_oe == PULL_RST) && !alert_n_oe)
    else $error("lines or alert not released after reset");

  a_write_loads: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_load |=> io_lines_oe == ~$past(rx))
    else $error("written byte not loaded into latches");

  a_write_ack: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_load |=> sda_oe && state == ST_WR_ACK)
    else $error("written byte not acknowledged");

  a_foreign_nack: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && state == ST_ADDR && scl_fall && full && !id_match && !start && !stop)
      |=> !sda_oe && state == ST_IGNORE)
    else $error("foreign identity acknowledged");

  a_sda_stable: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && scl_s && scl_q && !start && !stop) |=> $stable(sda_oe))
    else $error("data drive changed while clock high");

  a_read_snap: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && state == ST_ADDR_ACK && scl_rise && !start && !stop) |=> snap == $past(io_s))
    else $error("pins not sampled at identity acknowledge");

  a_first_bit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && state == ST_ADDR_ACK && scl_fall && is_read && !start && !stop)
      |=> state == ST_RD_DATA && sda_oe == !$past(snap[MSB]))
    else $error("first read bit not driven from snapshot");

  a_read_release: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_rearm |=> hold ##1 !alert_n_oe)
    else $error("alert not released at read acknowledge");

endmodule : ioxp_top

//--- hdl/ioxp_pkg.sv
// Shared constants and types of the octal I/O expander serial slave.
// Assumes one core clock domain; the bus pins are sampled, never used as clocks.
package ioxp_pkg;

  // ==========================================================================
  // Widths
  localparam int IO_W   = 8;                // Port lines
  localparam int ID_W   = 7;                // Slave identity bits
  localparam int STRP_W = 3;                // Identity straps

  // ==========================================================================
  // Identity and bit layout
  localparam logic [3:0] ID_HI_LOW_RANGE  = 4'h4;   // Upper identity bits, 0100 variant
  localparam logic [3:0] ID_HI_HIGH_RANGE = 4'h7;   // Upper identity bits, 0111 variant
  localparam logic       RW_READ          = 1'b1;   // Direction bit value of a read
  localparam logic [2:0] LAST_BIT         = 3'h7;   // Index of eighth bit of a byte
  localparam int         MSB              = IO_W - 1;

  // ==========================================================================
  // Reset values
  localparam logic [IO_W-1:0]   PULL_RST  = 8'h00;  // No line pulled: all latches high
  localparam logic [IO_W-1:0]   REF_RST   = 8'hff;  // Reference matches released lines
  localparam logic [IO_W-1:0]   IO_IDLE   = 8'hff;  // Synchroniser idle level of lines
  localparam logic [1:0]        BUS_IDLE  = 2'h3;   // Both bus wires idle high
  localparam logic [STRP_W-1:0] STRP_RST  = 3'h0;
  localparam logic [IO_W-1:0]   BYTE_RST  = 8'h00;
  localparam logic [2:0]        CNT_RST   = 3'h0;
  localparam logic              DRIVE_LOW = 1'b0;   // Open-drain pins only ever drive low

  // ==========================================================================
  // Bus state machine
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_DATA  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_DATA  = 3'b101,
    ST_RD_ACK   = 3'b110,
    ST_IGNORE   = 3'b111
  } ioxp_state_t;

endpackage : ioxp_pkg

//--- hdl/ioxp_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs are levels from outside the core clock domain.
module ioxp_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // ==========================================================================
  // First stage is read only by the second stage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      q    <= INIT;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : ioxp_sync

//--- hdl/ioxp_chg.sv
// Transition detector for the port lines and the change alert flop.
// Assumes synchronised pin levels and one-cycle rearm pulses from the bus logic.
module ioxp_chg
  import ioxp_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic [ioxp_pkg::IO_W-1:0] pins,
  input  wire logic [ioxp_pkg::IO_W-1:0] in_mask,
  input  wire logic                     rearm,
  input  wire logic [ioxp_pkg::IO_W-1:0] new_ref,
  input  wire logic                     hold,
  output logic                          alert
);

  logic [IO_W-1:0] ref_lvl;
  logic            differs;

  // Only released lines act as inputs; a pulled line always reads low
  assign differs = |((pins ^ ref_lvl) & in_mask);

  // ==========================================================================
  // Reference level, reloaded on every read or write acknowledge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ref_lvl <= REF_RST;
    else if (clk_en && rearm)
      ref_lvl <= new_ref;
  end

  // ==========================================================================
  // Alert follows the mismatch, so a line that returns to its level clears it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      alert <= 1'b0;
    else if (clk_en)
      alert <= differs && !hold && !rearm;
  end

  a_alert_tracks: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en |=> alert == ($past(differs) && !$past(hold) && !$past(rearm)))
    else $error("alert does not follow line mismatch");

  a_ref_reload: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && rearm) |=> ref_lvl == $past(new_ref))
    else $error("reference not reloaded from new_ref");

  a_hold_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && hold) |=> !alert)
    else $error("alert raised while held released");

endmodule : ioxp_chg

//--- tb/ioxp_bus_master.sv
// Bus master model that drives the expander's serial clock and data wire.
// Assumes the bench resolves the pulled-up data wire; moves on core_clk falls.
module ioxp_bus_master (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // =========================================================================
  // Idle bus: both wires released high, clock stands still between frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of the 320 ns bus clock period
  task automatic q();
    repeat (2) @(negedge core_clk);
  endtask : q

  // Data falls while clock high; also serves as repeated start
  task automatic start();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask : start

  // Data rises while clock high, then the bus is free
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop

  // Data changes mid-low only, so it is stable while clock is high
  task automatic bit_out(input logic b);
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    scl = 1'b0;
  endtask : bit_out

  // Release the wire and sample it in the middle of the high phase
  task automatic bit_in(output logic b);
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    b = sda;
    q();
    scl = 1'b0;
  endtask : bit_in

  // MSB first, ninth clock carries the receiver's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask : wr_byte

  // Master acknowledges all but the last byte it wants
  task automatic rd_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(~ack);
  endtask : rd_byte
endmodule : ioxp_bus_master

//--- tb/ioxp_top_tb.sv
// Self-checking bench for the octal expander serial slave.
// Assumes the bus master model; lines are wired-AND of latches and ext drivers.
module ioxp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ioxp_pkg::*;

  // =========================================================================
  // Signals and wires
  localparam logic [7:0] WR_ID = {ID_HI_LOW_RANGE, 3'h5, 1'b0};
  logic            core_clk = 1'b0;
  logic            rstn     = 1'b0;
  logic            clk_en   = 1'b1;
  logic            sda_oe_hi;
  logic [IO_W-1:0] io_oe_hi;
  logic            scl;
  logic            sda_low;
  logic            sda_out;
  logic            sda_oe;
  logic [IO_W-1:0] ext      = 8'hff;
  logic [IO_W-1:0] io_out;
  logic [IO_W-1:0] io_oe;
  logic            alert_out;
  logic            alert_oe;
  logic            ack;
  logic [7:0]      d1;
  logic [7:0]      d2;
  int              failures = 0;
  int              n_tests  = 0;
  // Pull-ups resolve released wires high
  wire             sda  = ~(sda_low | sda_oe | sda_oe_hi);
  wire [IO_W-1:0]  pins = ext & ~io_oe;

  always #20 core_clk = ~core_clk;

  ioxp_bus_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  ioxp_top #(.HIGH_RANGE(1'b0)) dut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_id_strap_0(1'b1),
    .slave_id_strap_1(1'b0), .slave_id_strap_2(1'b1), .io_lines_in(pins),
    .io_lines_out(io_out), .io_lines_oe(io_oe), .alert_n_out(alert_out),
    .alert_n_oe(alert_oe));

  // Second instance on the same bus, so the other identity range is decoded too
  ioxp_top #(.HIGH_RANGE(1'b1)) dut_hi (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe_hi), .slave_id_strap_0(1'b1),
    .slave_id_strap_1(1'b0), .slave_id_strap_2(1'b1), .io_lines_in(~io_oe_hi),
    .io_lines_out(), .io_lines_oe(io_oe_hi), .alert_n_out(),
    .alert_n_oe());

  // =========================================================================
  // Compare and helper tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  // Bounded wait: detector latency is a few cycles, 20 is ample
  task automatic wait_alert(input logic exp);
    for (int i = 0; i < 20 && alert_oe !== exp; i++)
      @(negedge core_clk);
  endtask : wait_alert

  task automatic wr_ports(input logic [7:0] d);
    m.start();
    m.wr_byte(WR_ID, ack);
    chk1(ack, 1'b1, "id ack");
    m.wr_byte(d, ack);
    chk1(ack, 1'b1, "data ack");
    m.stop();
  endtask : wr_ports

  // =========================================================================
  // Scenarios
  task automatic t_reset();
    chk8(io_oe, 8'h00, "latches");
    chk1(alert_oe, 1'b0, "alert");
    chk1(sda_oe | sda_out, 1'b0, "sda");
    chk8(io_out, 8'h00, "line value");
    chk1(alert_out, 1'b0, "alert value");
    chk8(io_oe_hi, 8'h00, "high latches");
    $display("t_reset done");
  endtask : t_reset

  // Identities foreign to both instances must be ignored
  task automatic t_foreign();
    logic [7:0] ids [2];
    ids = '{{ID_HI_HIGH_RANGE, 3'h6, 1'b0}, {ID_HI_LOW_RANGE, 3'h4, 1'b0}};
    foreach (ids[i])
    begin
      m.start();
      m.wr_byte(ids[i], ack);
      chk1(ack, 1'b0, "foreign id");
      m.wr_byte(8'h00, ack);
      chk1(ack, 1'b0, "ignored data");
      m.stop();
      chk8(io_oe, 8'h00, "latches kept");
    end
    $display("t_foreign done");
  endtask : t_foreign

  // Right straps in the other range: only the high-range instance answers
  task automatic t_range();
    m.start();
    m.wr_byte({ID_HI_HIGH_RANGE, 3'h5, 1'b0}, ack);
    chk1(ack, 1'b1, "high id ack");
    m.wr_byte(8'h96, ack);
    m.stop();
    chk8(io_oe_hi, 8'h69, "high lines");
    chk8(io_oe, 8'h00, "range kept");
    $display("t_range done");
  endtask : t_range

  // Clock enable low freezes detection; the change shows once enabled again
  task automatic t_freeze();
    clk_en = 1'b0;
    ext    = 8'hfe;
    repeat (10) @(negedge core_clk);
    chk1(alert_oe, 1'b0, "frozen");
    clk_en = 1'b1;
    wait_alert(1'b1);
    chk1(alert_oe, 1'b1, "thawed");
    ext = 8'hff;
    wait_alert(1'b0);
    $display("t_freeze done");
  endtask : t_freeze

  task automatic t_write();
    m.start();
    m.wr_byte(WR_ID, ack);
    chk1(ack, 1'b1, "id ack");
    m.wr_byte(8'h5a, ack);
    chk1(ack, 1'b1, "byte 1 ack");
    chk8(io_oe, 8'ha5, "byte 1 lines");
    m.wr_byte(8'hc3, ack);
    chk1(ack, 1'b1, "byte 2 ack");
    chk8(io_oe, 8'h3c, "byte 2 lines");
    m.stop();
    $display("t_write done");
  endtask : t_write

  // Line 7 driven low as output; four lines (2 to 5) change during the first byte
  task automatic t_read();
    wr_ports(8'h7f);
    ext = 8'hf3;
    m.start();
    m.wr_byte(WR_ID | 8'h01, ack);
    chk1(ack, 1'b1, "read id ack");
    fork
      m.rd_byte(d1, 1'b1);
      begin
        repeat (20) @(negedge core_clk);
        ext = 8'hcf;
      end
    join
    m.rd_byte(d2, 1'b0);
    m.stop();
    chk8(d1, 8'h73, "read byte 1");
    chk8(d2, 8'h4f, "read byte 2");
    $display("t_read done");
  endtask : t_read

  // Releasing line 7 moves it off the reference, so a second write rearms at all-high
  task automatic t_alert();
    ext = 8'hff;
    wr_ports(8'hff);
    wr_ports(8'hff);
    wait_alert(1'b0);
    chk1(alert_oe, 1'b0, "write rearms");
    ext = 8'hfe;
    wait_alert(1'b1);
    chk1(alert_oe, 1'b1, "edge raises");
    ext = 8'hff;
    wait_alert(1'b0);
    chk1(alert_oe, 1'b0, "return drops");
    ext = 8'hfd;
    wait_alert(1'b1);
    m.start();
    m.wr_byte(WR_ID | 8'h01, ack);
    m.rd_byte(d1, 1'b0);
    chk8(d1, 8'hfd, "read value");
    chk1(alert_oe, 1'b0, "read clears");
    ext = 8'hff;
    repeat (10) @(negedge core_clk);
    chk1(alert_oe, 1'b0, "held to stop");
    m.stop();
    wait_alert(1'b1);
    chk1(alert_oe, 1'b1, "new reference");
    m.start();
    m.wr_byte(WR_ID, ack);
    m.wr_byte(8'hff, ack);
    wait_alert(1'b0);
    chk1(alert_oe, 1'b0, "write clears");
    m.stop();
    $display("t_alert done");
  endtask : t_alert

  // =========================================================================
  // Verdict, main sequence and watchdog
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    repeat (8) @(negedge core_clk);
    t_reset();
    t_foreign();
    t_range();
    t_write();
    t_read();
    t_alert();
    t_freeze();
    wrap_up();
  end

  // Tests need about 75 us; a hang is cut well beyond that
  initial
  begin
    #600000;
    failures++;
    wrap_up();
  end
endmodule : ioxp_top_tb
